// file: hdl/frame_unit_params.svh
// Constants for the short exception frame unit: offsets, codes, sizes.
// Assumes a word-wide memory port toward the supervisor stacks.
// Operation
// - Return examines top frame, picks sequence by format
// - Format 0 restores status, pc, pops eight
// - Format 0 layout: status, pc at 2, word 6
// - Format 0 built for interrupts, traps, illegal, privilege
// - Throwaway pops eight, loads status, restarts return
// - After throwaway read new format from selected stack
// - Throwaway built on interrupt stack, master pc copied; code pushes format 1 on the status-selected stack, copies nothing
// - Format 1 same layout, code 0001
// - Format 2 restores, pops twelve, resumes
// - Format 2 adds address longword at offset 8
// - Format 2 for checks, traps, trace, divide, faults
// - Format 3 restores, pops twelve, pending fp starts
// - Format 3 only for fp post, ea at 8
`ifndef FRAME_UNIT_PARAMS_SVH
`define FRAME_UNIT_PARAMS_SVH
`define OFS_STATUS 32'h0000_0000
`define OFS_PC_HI 32'h0000_0002
`define OFS_PC_LO 32'h0000_0004
`define OFS_FMTVEC 32'h0000_0006
`define OFS_ADDR_HI 32'h0000_0008
`define OFS_ADDR_LO 32'h0000_000a
`define POP_SHORT 32'h0000_0008
`define POP_LONG 32'h0000_000c
`define FMT_NORMAL 4'h0
`define FMT_THROW 4'h1
`define FMT_SIX 4'h2
`define FMT_FPPOST 4'h3
`define VEC_FORMAT_ERR 12'h038
`define SR_S_BIT 13
`define SR_M_BIT 12
`define SR_RESET 16'h2700
`endif

// file: hdl/frame_unit_pkg.sv
// Types shared by the frame unit: state encoding.
// Assumes the params header supplies numeric constants.
`default_nettype none
package frame_unit_pkg;
    // Gray along rd fmt, decide, rd status, pc path
    typedef enum logic [3:0] {
        st_idle = 4'h0,
        st_rd_fmt = 4'h1,
        st_decide = 4'h3,
        st_rd_sr = 4'h2,
        st_rd_pch = 4'h6,
        st_rd_pcl = 4'h7,
        st_finish = 4'h5,
        st_wr_sr = 4'h4,
        st_wr_pch = 4'hc,
        st_wr_pcl = 4'hd,
        st_wr_fv = 4'hf,
        st_wr_ah = 4'he,
        st_wr_al = 4'ha
    } state_t;
endpackage
`default_nettype wire

// file: hdl/stack_select.sv
// Active supervisor stack picker from status bits.
// Assumes two stack pointer copies held by the caller.
`default_nettype none
`include "frame_unit_params.svh"
module stack_select (
    input wire logic [15:0] status_in,
    input wire logic [31:0] isp_in,
    input wire logic [31:0] msp_in,
    output logic use_master_out,
    output logic [31:0] sp_out
);
    // Master bit alone picks master stack; supervisor bit not examined
    assign use_master_out = status_in[`SR_M_BIT];
    assign sp_out = use_master_out ? msp_in : isp_in;
endmodule
`default_nettype wire

// file: hdl/exception_frame_return_unit.sv
// Return and frame build engine for short frames, formats 0 to 3.
// Assumes a word memory that answers a request with mem_ack_in later.
`default_nettype none
`include "frame_unit_params.svh"
module exception_frame_return_unit (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic rte_start_in,      // Pulse: run the return
    input wire logic build_start_in,    // Pulse: push a frame
    input wire logic [3:0] build_fmt_in, // Format to push
    input wire logic [11:0] build_vec_in, // Vector offset
    input wire logic [31:0] build_pc_in,  // Stacked pc
    input wire logic [31:0] build_addr_in, // Address or ea
    input wire logic [15:0] cur_status_in, // Live status word
    input wire logic [31:0] rte_pc_in,    // Address of the return
    input wire logic fp_post_pending_in,  // Another fp post waits
    input wire logic [31:0] isp_init_in,  // Loaded on reset release
    input wire logic [31:0] msp_init_in,
    input wire logic [15:0] mem_rdata_in,
    input wire logic mem_ack_in,
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [31:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    output logic [15:0] status_out,
    output logic [31:0] pc_out,
    output logic [31:0] isp_out,
    output logic [31:0] msp_out,
    output logic done_out,         // Pulse: push done, or return done and resume at pc_out
    output logic fp_post_start_out, // Pulse: begin next fp post
    output logic fmt_error_out      // Pulse: frame was bad
);
    frame_unit_pkg::state_t state;
    logic [15:0] status;     // Status being restored or built
    logic [31:0] pc;         // Pc being restored or built
    logic [3:0] fmt;         // Format being handled
    logic [11:0] vec;        // Vector offset being built
    logic [31:0] addr;       // Address longword being built
    logic [31:0] isp;        // Interrupt stack pointer
    logic [31:0] msp;        // Master stack pointer
    logic busy_build;        // Push path active
    logic rte_start_q;       // Holds the first format read back a cycle
    logic [31:0] sp;         // Active stack pointer
    logic use_master;
    logic seeded;            // Low until the first edge after release
    wire [31:0] next_sp_pop8 = sp + `POP_SHORT;
    wire [31:0] next_sp_pop12 = sp + `POP_LONG;
    wire fmt_known = (fmt == `FMT_NORMAL) || (fmt == `FMT_THROW) ||
        (fmt == `FMT_SIX) || (fmt == `FMT_FPPOST);
    wire long_frame = (fmt == `FMT_SIX) || (fmt == `FMT_FPPOST);
    wire [31:0] frame_bytes = long_frame ? `POP_LONG : `POP_SHORT;
    wire [31:0] push_base = sp - frame_bytes; // New frame top
    wire [15:0] fmt_word = {fmt, vec};

    // Active stack follows the status being restored
    stack_select u_sel (
        .status_in(status),
        .isp_in(isp),
        .msp_in(msp),
        .use_master_out(use_master),
        .sp_out(sp)
    );

    // Main sequencer
    always_ff @(posedge clk_in) begin
        done_out <= 1'b0;
        fp_post_start_out <= 1'b0;
        fmt_error_out <= 1'b0;
        rte_start_q <= 1'b0;
        if (srst_in) begin
            state <= frame_unit_pkg::st_idle;
            status <= `SR_RESET;
            pc <= 32'h0000_0000;
            fmt <= 4'h0;
            vec <= 12'h000;
            addr <= 32'h0000_0000;
            isp <= 32'h0000_0000;
            msp <= 32'h0000_0000;
            busy_build <= 1'b0;
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_addr_out <= 32'h0000_0000;
            mem_wdata_out <= 16'h0000;
        end else begin
            case (state)
                frame_unit_pkg::st_idle: begin
                    if (rte_start_in) begin
                        // Frame top lives on the stack of current status
                        status <= cur_status_in;
                        pc <= rte_pc_in;
                        rte_start_q <= 1'b1;
                        state <= frame_unit_pkg::st_rd_fmt;
                    end else if (build_start_in) begin
                        status <= cur_status_in;
                        fmt <= build_fmt_in;
                        vec <= build_vec_in;
                        pc <= build_pc_in;
                        addr <= build_addr_in;
                        busy_build <= 1'b1;
                        state <= frame_unit_pkg::st_wr_sr;
                    end
                end
                frame_unit_pkg::st_rd_fmt: begin
                    // Fetch format word from whichever stack is active
                    if (!mem_req_out && !rte_start_q) begin
                        mem_req_out <= 1'b1;
                        mem_we_out <= 1'b0;
                        mem_addr_out <= sp + `OFS_FMTVEC;
                    end else if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        fmt <= mem_rdata_in[15:12];
                        vec <= mem_rdata_in[11:0];
                        state <= frame_unit_pkg::st_decide;
                    end
                end
                frame_unit_pkg::st_decide: begin
                    if (fmt_known) begin
                        state <= frame_unit_pkg::st_rd_sr;
                    end else begin
                        // Bad code: push a format 0 frame at the return
                        fmt <= `FMT_NORMAL;
                        vec <= `VEC_FORMAT_ERR;
                        busy_build <= 1'b1;
                        fmt_error_out <= 1'b1;
                        state <= frame_unit_pkg::st_wr_sr;
                    end
                end
                frame_unit_pkg::st_rd_sr: begin
                    if (!mem_req_out) begin
                        mem_req_out <= 1'b1;
                        mem_addr_out <= sp + `OFS_STATUS;
                    end else if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        if (fmt == `FMT_THROW) begin
                            // Pop old stack, then switch by new status
                            if (use_master) msp <= next_sp_pop8;
                            else isp <= next_sp_pop8;
                            status <= mem_rdata_in;
                            state <= frame_unit_pkg::st_rd_fmt;
                        end else begin
                            status <= status; // Keep old until popped
                            addr[31:16] <= mem_rdata_in;
                            state <= frame_unit_pkg::st_rd_pch;
                        end
                    end
                end
                frame_unit_pkg::st_rd_pch: begin
                    if (!mem_req_out) begin
                        mem_req_out <= 1'b1;
                        mem_addr_out <= sp + `OFS_PC_HI;
                    end else if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        pc[31:16] <= mem_rdata_in;
                        state <= frame_unit_pkg::st_rd_pcl;
                    end
                end
                frame_unit_pkg::st_rd_pcl: begin
                    if (!mem_req_out) begin
                        mem_req_out <= 1'b1;
                        mem_addr_out <= sp + `OFS_PC_LO;
                    end else if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        pc[15:0] <= mem_rdata_in;
                        // Pop from the stack the frame sat on
                        if (long_frame) begin
                            if (use_master) msp <= next_sp_pop12;
                            else isp <= next_sp_pop12;
                        end else begin
                            if (use_master) msp <= next_sp_pop8;
                            else isp <= next_sp_pop8;
                        end
                        state <= frame_unit_pkg::st_finish;
                    end
                end
                frame_unit_pkg::st_finish: begin
                    if (busy_build) begin
                        busy_build <= 1'b0;
                        done_out <= 1'b1;
                    end else begin
                        status <= addr[31:16];
                        if (fmt == `FMT_FPPOST && fp_post_pending_in)
                            fp_post_start_out <= 1'b1;
                        else
                            done_out <= 1'b1;
                    end
                    state <= frame_unit_pkg::st_idle;
                end
                frame_unit_pkg::st_wr_sr: begin
                    if (!mem_req_out) begin
                        mem_req_out <= 1'b1;
                        mem_we_out <= 1'b1;
                        mem_addr_out <= push_base + `OFS_STATUS;
                        mem_wdata_out <= status;
                    end else if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        state <= frame_unit_pkg::st_wr_pch;
                    end
                end
                frame_unit_pkg::st_wr_pch: begin
                    if (!mem_req_out) begin
                        mem_req_out <= 1'b1;
                        mem_addr_out <= push_base + `OFS_PC_HI;
                        mem_wdata_out <= pc[31:16];
                    end else if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        state <= frame_unit_pkg::st_wr_pcl;
                    end
                end
                frame_unit_pkg::st_wr_pcl: begin
                    if (!mem_req_out) begin
                        mem_req_out <= 1'b1;
                        mem_addr_out <= push_base + `OFS_PC_LO;
                        mem_wdata_out <= pc[15:0];
                    end else if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        state <= frame_unit_pkg::st_wr_fv;
                    end
                end
                frame_unit_pkg::st_wr_fv: begin
                    if (!mem_req_out) begin
                        mem_req_out <= 1'b1;
                        mem_addr_out <= push_base + `OFS_FMTVEC;
                        mem_wdata_out <= fmt_word;
                    end else if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        state <= long_frame ? frame_unit_pkg::st_wr_ah
                                            : frame_unit_pkg::st_finish;
                        if (!long_frame) begin
                            if (use_master) msp <= push_base;
                            else isp <= push_base;
                        end
                    end
                end
                frame_unit_pkg::st_wr_ah: begin
                    if (!mem_req_out) begin
                        mem_req_out <= 1'b1;
                        mem_addr_out <= push_base + `OFS_ADDR_HI;
                        mem_wdata_out <= addr[31:16];
                    end else if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        state <= frame_unit_pkg::st_wr_al;
                    end
                end
                frame_unit_pkg::st_wr_al: begin
                    if (!mem_req_out) begin
                        mem_req_out <= 1'b1;
                        mem_addr_out <= push_base + `OFS_ADDR_LO;
                        mem_wdata_out <= addr[15:0];
                    end else if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        if (use_master) msp <= push_base;
                        else isp <= push_base;
                        state <= frame_unit_pkg::st_finish;
                    end
                end
                default: state <= frame_unit_pkg::st_idle;
            endcase
            // Seeds caught on the first edge after release; placed last
            // so it wins over anything the sequencer did on that edge
            if (!seeded) begin
                isp <= isp_init_in;
                msp <= msp_init_in;
            end
        end
    end

    // Marks the first edge after release, when the pointers load
    always_ff @(posedge clk_in) begin
        if (srst_in) seeded <= 1'b0;
        else seeded <= 1'b1;
    end

    // Registered copies to the ports
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            status_out <= `SR_RESET;
            pc_out <= 32'h0000_0000;
            isp_out <= 32'h0000_0000;
            msp_out <= 32'h0000_0000;
        end else begin
            status_out <= status;
            pc_out <= pc;
            isp_out <= isp;
            msp_out <= msp;
        end
    end

    // Format 0 pop is exactly eight bytes
    chk_pop_eight: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == frame_unit_pkg::st_rd_pcl && mem_ack_in && mem_req_out &&
         fmt == `FMT_NORMAL && !busy_build && !use_master)
        |=> isp == $past(isp) + `POP_SHORT)
        else $error("format 0 pop wrong");
    // Unknown format raises error flag
    chk_bad_format: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == frame_unit_pkg::st_decide && !fmt_known)
        |=> fmt_error_out)
        else $error("format error missed");
    // Throwaway restarts with a format read
    chk_throw_restart: assert property (@(posedge clk_in)
        disable iff (srst_in)
        (state == frame_unit_pkg::st_rd_sr && mem_ack_in && mem_req_out &&
         fmt == `FMT_THROW)
        |=> state == frame_unit_pkg::st_rd_fmt && !done_out)
        else $error("throwaway did not restart");
    // Pending fp post starts instead of resuming
    chk_fp_next: assert property (@(posedge clk_in) disable iff (srst_in)
        (state == frame_unit_pkg::st_finish && !busy_build &&
         fmt == `FMT_FPPOST && fp_post_pending_in)
        |=> fp_post_start_out && !done_out)
        else $error("fp post not chained");
    // Long frames pop exactly twelve bytes
    chk_pop_twelve: assert property (@(posedge clk_in)
        disable iff (srst_in)
        (state == frame_unit_pkg::st_rd_pcl && mem_ack_in && mem_req_out &&
         long_frame && !busy_build && !use_master)
        |=> isp == $past(isp) + `POP_LONG)
        else $error("long frame pop wrong");
    // Format word read from the stack the status selects
    chk_fmt_addr: assert property (@(posedge clk_in)
        disable iff (srst_in)
        (state == frame_unit_pkg::st_rd_fmt && mem_req_out)
        |-> !mem_we_out && mem_addr_out ==
            (status[`SR_M_BIT] ? msp : isp) + `OFS_FMTVEC)
        else $error("format word address wrong");
endmodule
`default_nettype wire

// file: test/stack_memory.sv
// Word memory model standing for the supervisor stacks.
// Assumes requests are held until ack and get one ack each.
`default_nettype none
module stack_memory (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [3:0] latency_in,
    input wire logic mem_req_in,
    input wire logic mem_we_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [15:0] mem_wdata_in,
    output logic [15:0] mem_rdata_out,
    output logic mem_ack_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] words [0:255]; // Stack words, byte address bits 8:1
    logic [3:0] wait_cnt; // Cycles spent on this request
    logic cool; // Edge after an ack, request still up
    logic holding; // A request is being served
    logic [31:0] held_addr; // Address seen on the previous edge
    int hold_errs = 0; // Requests that moved before their ack
    int n_acks = 0; // Acks given since time zero
    initial mem_rdata_out = 16'h0000;
    initial mem_ack_out = 1'b0;
    // One word per request; read data toggles when not answering,
    // so a late sample never sees a stale but plausible word
    always @(posedge clk_in) begin
        mem_ack_out <= 1'b0;
        mem_rdata_out <= ~mem_rdata_out;
        if (srst_in) begin
            wait_cnt <= 4'h0;
            cool <= 1'b0;
            holding <= 1'b0;
        end else if (cool) begin
            cool <= 1'b0;
        end else if (mem_req_in) begin
            // Address must stand until the ack
            if (holding && mem_addr_in !== held_addr)
                hold_errs++;
            holding <= 1'b1;
            held_addr <= mem_addr_in;
            if (wait_cnt >= latency_in) begin
                mem_ack_out <= 1'b1;
                cool <= 1'b1;
                holding <= 1'b0;
                wait_cnt <= 4'h0;
                n_acks++;
                if (mem_we_in)
                    words[mem_addr_in[8:1]] <= mem_wdata_in;
                else
                    mem_rdata_out <= words[mem_addr_in[8:1]];
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/exception_frame_return_unit_test.sv
// Self-checking bench for the short frame return and build engine.
// Assumes the stack memory model answers the word port.
`default_nettype none
module exception_frame_return_unit_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] ISP0 = 32'h0000_0080; // Interrupt stack seed
    localparam logic [31:0] MSP0 = 32'h0000_0100; // Master stack seed
    localparam logic [31:0] RPC = 32'h0000_1234; // Address of the return
    typedef struct {
        logic [3:0] fmt;
        logic fp;
        logic [1:0] kind;
        logic [31:0] sp;
    } row_t;
    logic clk_in = 1'b0, srst_in = 1'b1, rte_start_in = 1'b0;
    logic build_start_in = 1'b0, fp_post_pending_in = 1'b0;
    logic [3:0] build_fmt_in = 4'h0, latency = 4'h0;
    logic [11:0] build_vec_in = 12'h000;
    logic [31:0] build_pc_in = 32'h0, build_addr_in = 32'h0;
    logic [15:0] mem_rdata_in;
    logic mem_ack_in, mem_req_out, mem_we_out;
    logic [31:0] mem_addr_out, pc_out, isp_out, msp_out;
    logic [15:0] mem_wdata_out, status_out;
    logic done_out, fp_post_start_out, fmt_error_out;
    logic [1:0] kind;
    row_t rows [6];
    int error_cnt = 0, n_checks = 0, cycles = 0, i, b, n, size, acks0;
    exception_frame_return_unit dut (.clk_in(clk_in), .srst_in(srst_in),
        .rte_start_in(rte_start_in), .build_start_in(build_start_in),
        .build_fmt_in(build_fmt_in), .build_vec_in(build_vec_in),
        .build_pc_in(build_pc_in), .build_addr_in(build_addr_in),
        .cur_status_in(16'h2700), .rte_pc_in(RPC),
        .fp_post_pending_in(fp_post_pending_in), .isp_init_in(ISP0),
        .msp_init_in(MSP0), .mem_rdata_in(mem_rdata_in),
        .mem_ack_in(mem_ack_in), .mem_req_out(mem_req_out),
        .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .status_out(status_out),
        .pc_out(pc_out), .isp_out(isp_out), .msp_out(msp_out),
        .done_out(done_out), .fp_post_start_out(fp_post_start_out),
        .fmt_error_out(fmt_error_out));
    stack_memory mem (.clk_in(clk_in), .srst_in(srst_in),
        .latency_in(latency), .mem_req_in(mem_req_out),
        .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out),
        .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in),
        .mem_ack_out(mem_ack_in));
    // 40 MHz clock
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // Hang guard, far above the longest expected run
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // Short reset, then the two edges before a request may start
    task automatic do_reset();
        @(posedge clk_in);
        #1 srst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 srst_in = 1'b0;
        repeat (2) @(posedge clk_in);
    endtask
    // One-cycle start pulse, return or build
    task automatic pulse(input logic build);
        @(posedge clk_in);
        #1 rte_start_in = ~build;
        build_start_in = build;
        @(posedge clk_in);
        #1 rte_start_in = 1'b0;
        build_start_in = 1'b0;
    endtask
    // Which pulse ends the run; a format error is kept while its frame
    // push runs on to done; each pulse stands one cycle only
    task automatic wait_end(output logic [1:0] k);
        logic fin;
        k = 2'h0;
        fin = 1'b0;
        for (int t = 0; t < 400 && !fin; t++) begin
            @(negedge clk_in);
            if (fmt_error_out === 1'b1) k = 2'h3;
            if (done_out === 1'b1 || fp_post_start_out === 1'b1) begin
                fin = 1'b1;
                if (k === 2'h0) k = done_out ? 2'h1 : 2'h2;
            end
        end
        @(negedge clk_in);
        check({done_out, fp_post_start_out, fmt_error_out}, 3'h0);
    endtask
    // Frame words straight into the model, high pc word first
    task automatic put_frame(input logic [31:0] sp, input logic [3:0] fmt,
            input logic [15:0] sr, input logic [31:0] pc);
        int w;
        w = sp[8:1];
        mem.words[w] = sr;
        mem.words[w + 1] = pc[31:16];
        mem.words[w + 2] = pc[15:0];
        mem.words[w + 3] = {fmt, 12'h0c0};
    endtask
    initial begin
        rows = '{'{4'h0, 1'b0, 2'h1, ISP0 + 8}, '{4'h2, 1'b0, 2'h1, ISP0 + 12},
            '{4'h3, 1'b0, 2'h1, ISP0 + 12}, '{4'h3, 1'b1, 2'h2, ISP0 + 12},
            '{4'h4, 1'b0, 2'h3, ISP0 - 8}, '{4'hf, 1'b0, 2'h3, ISP0 - 8}};
        repeat (10) @(posedge clk_in);
        #1 check(status_out, 16'h2700); // Reset state
        check({mem_req_out, done_out, fp_post_start_out, fmt_error_out}, 0);
        check(isp_out, 32'h0);
        srst_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 check(isp_out, ISP0);
        check(msp_out, MSP0);
        // Return over formats 0, 2, 3 and two bad codes, fast and slow memory
        for (i = 0; i < 6; i++) begin
            do_reset();
            latency = 4'(i % 3);
            put_frame(ISP0, rows[i].fmt, 16'h2010 + 16'(i), 32'h4000 + i);
            fp_post_pending_in = rows[i].fp;
            pulse(1'b0);
            wait_end(kind);
            check(kind, rows[i].kind);
            check(isp_out, rows[i].sp);
            if (rows[i].kind != 2'h3) begin
                check(status_out, 16'h2010 + 16'(i));
                check(pc_out, 32'h4000 + i);
            end else begin
                b = ISP0[8:1] - 4;
                check({mem.words[b + 1], mem.words[b + 2]}, RPC);
                check(mem.words[b + 3], 16'h0038);
            end
        end
        fp_post_pending_in = 1'b0;
        // Throwaway into throwaway on the same stack, then master stack
        do_reset();
        latency = 4'h3;
        put_frame(ISP0, 4'h1, 16'h2000, 32'h0);
        put_frame(ISP0 + 8, 4'h1, 16'h3000, 32'h0);
        put_frame(MSP0, 4'h0, 16'h3004, 32'h0000_5678);
        pulse(1'b0);
        wait_end(kind);
        check(kind, 2'h1);
        check(isp_out, ISP0 + 16);
        check(msp_out, MSP0 + 8);
        check(status_out, 16'h3004);
        check(pc_out, 32'h0000_5678);
        // Build each short format, then return through all but format 1
        latency = 4'h1;
        for (i = 0; i < 4; i++) begin
            do_reset();
            size = (i < 2) ? 8 : 12;
            acks0 = mem.n_acks;
            build_fmt_in = 4'(i);
            build_vec_in = 12'h060 + 12'(i);
            build_pc_in = 32'habcd_0010;
            build_addr_in = 32'h5555_aaaa;
            pulse(1'b1);
            for (n = 0; n < 400 && mem.n_acks < acks0 + size / 2; n++)
                @(negedge clk_in);
            repeat (2) @(negedge clk_in);
            b = ISP0[8:1] - size / 2;
            check(isp_out, ISP0 - size);
            check(mem.words[b], 16'h2700);
            check({mem.words[b + 1], mem.words[b + 2]}, 32'habcd_0010);
            check(mem.words[b + 3], {4'(i), 12'h060 + 12'(i)});
            if (i > 1) begin
                check({mem.words[b + 4], mem.words[b + 5]}, 32'h5555_aaaa);
            end
            if (i != 1) begin
                build_pc_in = 32'h0;
                pulse(1'b0);
                wait_end(kind);
                check(kind, 2'h1);
                check(pc_out, 32'habcd_0010);
                check(isp_out, ISP0);
            end
        end
        check(mem.hold_errs, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
